// *** rtl/ddrp_params.svh ***
`ifndef DDRP_PARAMS_SVH
`define DDRP_PARAMS_SVH

`define DDRP_W            8
`define DDRP_CNT_W        2
`define DDRP_CNT_RST      2'h0
`define DDRP_CNT_PRE_RISE 2'h1
`define DDRP_CNT_PRE_FALL 2'h3
`define DDRP_SLOT_A_FIRST 2'h2
`define DDRP_SLOT_A_SEC   2'h3
`define DDRP_SLOT_B_FIRST 2'h0
`define DDRP_SLOT_B_SEC   2'h1
`define DDRP_DATA_RST     8'h00
`define DDRP_SYNC_STAGES  2

`endif

// *** rtl/ddrp_pkg.sv ***
`include "ddrp_params.svh"

package ddrp_pkg;

  typedef enum logic [1:0] {
    DDRP_SDR_FF    = 2'b00,
    DDRP_SDR_LATCH = 2'b01,
    DDRP_DDR       = 2'b10,
    DDRP_GEAR      = 2'b11
  } ddrp_mode_e;

  typedef enum logic [1:0] {
    DDRP_IDLE  = 2'b00,
    DDRP_ARM   = 2'b01,
    DDRP_BURST = 2'b10
  } ddrp_rd_e;

  typedef logic [`DDRP_W-1:0] ddrp_data_t;

  typedef struct packed {
    logic [`DDRP_CNT_W-1:0] cnt;
    ddrp_data_t             first_q;
    ddrp_data_t             second_q;
    ddrp_data_t             second_lat;
    ddrp_data_t             sdr_q;
    ddrp_data_t             ga_first;
    ddrp_data_t             ga_second;
    ddrp_data_t             gb_first;
    ddrp_data_t             gb_second;
    ddrp_data_t             pad;
    ddrp_rd_e               st;
    logic                   edge_sel;
    logic                   strobe_prev;
    ddrp_data_t             stage;
    logic                   stage_new;
    ddrp_data_t             rdata;
    logic                   rvalid;
  } ddrp_state_s;

endpackage

// *** rtl/ddrp_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser; only the second stage is visible
module ddrp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

// *** rtl/ddrp_io_path.sv ***
`timescale 1ns/100ps
`default_nettype none

`include "ddrp_params.svh"

module ddrp_io_path (
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,
  input  wire ddrp_pkg::ddrp_mode_e  mode_i,
  input  wire logic [`DDRP_W-1:0]    out_data_first_phase_i,
  input  wire logic [`DDRP_W-1:0]    out_data_second_phase_i,
  input  wire logic [`DDRP_W-1:0]    gearbox_stream_a_first_i,
  input  wire logic [`DDRP_W-1:0]    gearbox_stream_a_second_i,
  input  wire logic [`DDRP_W-1:0]    gearbox_stream_b_first_i,
  input  wire logic [`DDRP_W-1:0]    gearbox_stream_b_second_i,
  input  wire logic                  write_en_i,
  input  wire logic                  read_start_i,
  input  wire logic                  read_done_i,
  input  wire logic                  strobe_i,
  input  wire logic [`DDRP_W-1:0]    read_pad_i,
  output logic      [`DDRP_W-1:0]    pad_output_value_o,
  output logic                       out_clk_o,
  output logic                       write_strobe_quarter_shift_o,
  output logic                       write_strobe_oe_o,
  output logic                       sync_clock_edge_select_o,
  output logic      [`DDRP_W-1:0]    read_data_o,
  output logic                       read_valid_o,
  output logic                       read_busy_o
);

  // ==========================================================
  // Pin synchronisers
  logic                 strobe_s;
  logic                 strobe_n_s;
  logic [`DDRP_W-1:0]   rpad_s;

  // Synchronised inverted so reset matches idle-high pin; no false preamble
  ddrp_sync #(.W(1)) u_sync_strobe (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (~strobe_i),
    .sync_o    (strobe_n_s)
  );

  assign strobe_s = ~strobe_n_s;

  ddrp_sync #(.W(`DDRP_W)) u_sync_rpad (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (read_pad_i),
    .sync_o    (rpad_s)
  );

  // ==========================================================
  // State
  ddrp_pkg::ddrp_state_s s;
  ddrp_pkg::ddrp_state_s next_s;
  logic                  rise_en;
  logic                  fall_en;
  logic                  next_oclk;
  logic                  pre_fall;
  logic                  sync_en;

  assign rise_en   = (s.cnt == `DDRP_CNT_PRE_RISE);
  assign fall_en   = (s.cnt == `DDRP_CNT_PRE_FALL);
  // Termination holds the idle strobe high; preamble pulls it low
  assign pre_fall  = s.strobe_prev & ~strobe_s;
  assign sync_en   = s.edge_sel ? fall_en : rise_en;

  always_comb
  begin
    next_s     = s;
    next_s.cnt = s.cnt + `DDRP_CNT_W'(1);
    next_oclk  = next_s.cnt[`DDRP_CNT_W-1];

    if (rise_en)
    begin
      next_s.first_q  = out_data_first_phase_i;
      next_s.second_q = out_data_second_phase_i;
    end
    if (fall_en)
      next_s.second_lat = s.second_q;

    if ((mode_i == ddrp_pkg::DDRP_SDR_FF && rise_en) ||
        (mode_i == ddrp_pkg::DDRP_SDR_LATCH && next_oclk))
      next_s.sdr_q = out_data_first_phase_i;

    if (rise_en)
    begin
      next_s.ga_first  = gearbox_stream_a_first_i;
      next_s.ga_second = gearbox_stream_a_second_i;
      next_s.gb_first  = gearbox_stream_b_first_i;
      next_s.gb_second = gearbox_stream_b_second_i;
    end

    // mode decides which storage feeds the pad
    unique case (mode_i)
      ddrp_pkg::DDRP_SDR_FF,
      ddrp_pkg::DDRP_SDR_LATCH:
        next_s.pad = next_s.sdr_q;
      ddrp_pkg::DDRP_DDR:
        next_s.pad = next_oclk ? next_s.first_q : next_s.second_lat;
      ddrp_pkg::DDRP_GEAR:
        unique case (next_s.cnt)
          `DDRP_SLOT_A_FIRST: next_s.pad = next_s.ga_first;
          `DDRP_SLOT_A_SEC:   next_s.pad = next_s.ga_second;
          `DDRP_SLOT_B_FIRST: next_s.pad = next_s.gb_first;
          `DDRP_SLOT_B_SEC:   next_s.pad = next_s.gb_second;
        endcase
    endcase

    // Read side
    next_s.strobe_prev = strobe_s;
    next_s.rvalid      = 1'b0;
    unique case (s.st)
      ddrp_pkg::DDRP_IDLE:
        if (read_start_i)
          next_s.st = ddrp_pkg::DDRP_ARM;
      ddrp_pkg::DDRP_ARM:
        if (pre_fall)
        begin
          next_s.st       = ddrp_pkg::DDRP_BURST;
          next_s.edge_sel = s.cnt[`DDRP_CNT_W-1];
        end
      ddrp_pkg::DDRP_BURST:
      begin
        if (s.strobe_prev != strobe_s)
        begin
          next_s.stage     = rpad_s;
          next_s.stage_new = 1'b1;
        end
        if (read_done_i)
          next_s.st = ddrp_pkg::DDRP_IDLE;
      end
      default:
        next_s.st = ddrp_pkg::DDRP_IDLE;
    endcase

    if (sync_en && s.stage_new)
    begin
      next_s.rdata     = s.stage;
      next_s.rvalid    = 1'b1;
      next_s.stage_new = (s.st == ddrp_pkg::DDRP_BURST) && (s.strobe_prev != strobe_s);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      s             <= '0;
      s.cnt         <= `DDRP_CNT_RST;
      s.st          <= ddrp_pkg::DDRP_IDLE;
      s.strobe_prev <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // Outputs
  assign pad_output_value_o           = s.pad;
  assign out_clk_o                    = s.cnt[`DDRP_CNT_W-1];
  assign write_strobe_quarter_shift_o = s.cnt[1] ~^ s.cnt[0];
  assign write_strobe_oe_o            = write_en_i;
  assign sync_clock_edge_select_o     = s.edge_sel;
  assign read_data_o                  = s.rdata;
  assign read_valid_o                 = s.rvalid;
  assign read_busy_o                  = (s.st != ddrp_pkg::DDRP_IDLE);

  // ==========================================================
  // Checks
  chk_ddr_first_half: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (s.cnt == `DDRP_SLOT_A_FIRST && $past(mode_i) == ddrp_pkg::DDRP_DDR)
      |-> s.pad == $past(out_data_first_phase_i))
    else $error("ddr first half wrong");

  chk_ddr_second_half: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (s.cnt == `DDRP_SLOT_B_FIRST && $past(mode_i) == ddrp_pkg::DDRP_DDR &&
     $past(mode_i, 3) == ddrp_pkg::DDRP_DDR)
      |-> s.pad == $past(out_data_second_phase_i, 3))
    else $error("ddr second half wrong");

  chk_sdr_ff_hold: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (mode_i == ddrp_pkg::DDRP_SDR_FF && $past(mode_i) == ddrp_pkg::DDRP_SDR_FF &&
     s.cnt != `DDRP_SLOT_A_FIRST) |-> $stable(pad_output_value_o))
    else $error("sdr flop changed off edge");

  chk_gear_order: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (s.cnt == `DDRP_SLOT_B_SEC && $past(mode_i) == ddrp_pkg::DDRP_GEAR &&
     $past(s.cnt, 4) == `DDRP_SLOT_B_SEC)
      |-> s.pad == $past(gearbox_stream_b_second_i, 4))
    else $error("gearbox slot wrong");

  chk_pol_eval: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (s.st == ddrp_pkg::DDRP_ARM && pre_fall)
      |=> (s.st == ddrp_pkg::DDRP_BURST && s.edge_sel == $past(out_clk_o)))
    else $error("polarity not set at preamble");

  chk_pol_hold: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (s.st == ddrp_pkg::DDRP_BURST && $past(s.st) == ddrp_pkg::DDRP_BURST)
      |-> $stable(sync_clock_edge_select_o))
    else $error("polarity moved in burst");

  chk_read_arm: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (s.st == ddrp_pkg::DDRP_IDLE && read_start_i) |=> s.st == ddrp_pkg::DDRP_ARM)
    else $error("read not armed");

  chk_sync_phase: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    read_valid_o |-> (s.edge_sel ? s.cnt == `DDRP_SLOT_B_FIRST : s.cnt == `DDRP_SLOT_A_FIRST))
    else $error("sync on wrong edge");

  chk_quarter_shift: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(out_clk_o) |=> $rose(write_strobe_quarter_shift_o) ##2 $fell(write_strobe_quarter_shift_o))
    else $error("write strobe not shifted");

  cov_ddr: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    mode_i == ddrp_pkg::DDRP_DDR && s.cnt == `DDRP_SLOT_B_FIRST);
  cov_gear: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    mode_i == ddrp_pkg::DDRP_GEAR && s.cnt == `DDRP_SLOT_B_SEC);
  cov_neg_edge: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    read_valid_o && s.edge_sel);
  cov_read: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s.st == ddrp_pkg::DDRP_BURST ##1 read_valid_o);

endmodule

`default_nettype wire

// *** verif/ddrp_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Memory side of the strobe bus, 48 ns strobe
module ddrp_mem_model (
  input  wire logic        go_i,
  input  wire logic        done_i,
  input  wire logic [31:0] words_i,
  output logic             strobe_o,
  output logic [7:0]       dq_o
);
  int k;

  initial
  begin
    strobe_o = 1'b1;
    dq_o     = 8'h5a;
    forever
    begin
      @(posedge go_i);
      strobe_o = 1'b0;
      #12 dq_o = words_i[7:0];
      #12;
      for (k = 0; k < 4; k++)
      begin
        strobe_o = ~strobe_o;
        // Data moves mid-bit, well clear of each strobe edge
        #12 dq_o = (k < 3) ? words_i[8*(k+1)+:8] : ~dq_o;
        #12;
      end
      @(posedge done_i);
      strobe_o = 1'b1;
      dq_o     = ~dq_o;
    end
  end
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic                 clk, rstn, wen, rs, rd, go, strobe, busy, rv, oclk, qs, oe, esel, sel0;
  ddrp_pkg::ddrp_mode_e mode;
  logic [7:0]           f, s, a1, a2, b1, b2, rpad, pad, rdat;
  logic [31:0]          words, e;
  logic [31:0]          exp_q[$];
  logic [7:0]           rd_q[$];
  int                   num_errors = 0, tests_run = 0, cycles = 0, nv = 0, i, j;

  ddrp_io_path ddrp_io_path_inst (.ref_clk_i(clk), .resetn_i(rstn), .mode_i(mode),
    .out_data_first_phase_i(f), .out_data_second_phase_i(s), .gearbox_stream_a_first_i(a1),
    .gearbox_stream_a_second_i(a2), .gearbox_stream_b_first_i(b1), .gearbox_stream_b_second_i(b2),
    .write_en_i(wen), .read_start_i(rs), .read_done_i(rd), .strobe_i(strobe), .read_pad_i(rpad),
    .pad_output_value_o(pad), .out_clk_o(oclk), .write_strobe_quarter_shift_o(qs),
    .write_strobe_oe_o(oe), .sync_clock_edge_select_o(esel), .read_data_o(rdat),
    .read_valid_o(rv), .read_busy_o(busy));

  ddrp_mem_model ddrp_mem_model_inst (.go_i(go), .done_i(rd), .words_i(words), .strobe_o(strobe),
    .dq_o(rpad));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================
  // Output path: one data set per output period
  task automatic send(input ddrp_pkg::ddrp_mode_e m);
    do @(negedge clk); while (!(oclk === 1'b0 && qs === 1'b0));
    mode = m;
    {f, s, a1, a2} = $urandom;
    {b1, b2} = 16'($urandom);
    wen = 1'($urandom);
    case (m)
      ddrp_pkg::DDRP_DDR:  exp_q.push_back({f, f, s, s});
      ddrp_pkg::DDRP_GEAR: exp_q.push_back({a1, a2, b1, b2});
      default:             exp_q.push_back({f, f, f, f});
    endcase
  endtask

  initial
  begin
    forever
    begin
      @(negedge clk);
      if (exp_q.size() > 0 && oclk === 1'b1 && qs === 1'b0)
      begin
        e = exp_q.pop_front();
        check(32'(oe), 32'(wen));
        for (j = 0; j < 4; j++)
        begin
          if (j > 0)
            @(negedge clk);
          check(32'(pad), 32'(e[31-8*j-:8]));
          check(32'({oclk, qs}), 32'(8'hb4 >> (6 - 2 * j)) & 32'h3);
        end
      end
    end
  end

  // ==========================================
  // Read path: words in strobe order, polarity held
  always @(negedge clk)
    if (rv === 1'b1)
    begin
      check(32'(rdat), 32'(rd_q.pop_front()));
      check(32'({esel, busy}), 32'({sel0, 1'b1}));
      nv++;
    end

  task automatic do_read;
    int n;
    words = $urandom;
    for (n = 0; n < 4; n++)
      rd_q.push_back(words[8*n+:8]);
    nv = 0;
    @(negedge clk);
    rs = 1'b1;
    @(negedge clk);
    rs = 1'b0;
    check(32'(busy), 32'h1);
    #($urandom_range(0, 47)) go = 1'b1;
    // Preamble reaches the detector two edges later; polarity is the output clock then
    repeat (2) @(posedge clk);
    @(negedge clk);
    sel0 = oclk;
    n = 0;
    while (nv < 4 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(nv), 32'h4);
    repeat (6) @(negedge clk);
    rd = 1'b1;
    go = 1'b0;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    check(32'(busy), 32'h0);
  endtask

  initial
  begin
    void'($urandom(32'h7007a4c0));
    {rstn, wen, rs, rd, go, f, s, a1, a2, b1, b2, words} = '0;
    mode = ddrp_pkg::DDRP_SDR_FF;
    repeat (2) @(negedge clk);
    check(32'({pad, oclk, qs, esel, busy, rv}), 32'h008);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 16; i++)
      send(ddrp_pkg::ddrp_mode_e'(i % 4));
    repeat (8) @(negedge clk);
    // Random strobe phase gives both polarities across reads
    for (i = 0; i < 6; i++)
      do_read();
    complete_run();
  end
endmodule

`default_nettype wire
